// ---- tcw_pkg.sv ----
// constants and types of the compare waveform generator
package tcw_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NCH = 8;
  localparam int CNT_W = 16;
  localparam int CTRL_W = 7;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CMP0 = 8'h20;
  localparam logic [7:0] OFS_FSEL = 8'h40;
  localparam logic [7:0] OFS_FEN = 8'h44;
  localparam logic [7:0] OFS_ISTAT = 8'h48;
  localparam logic [7:0] OFS_IMASK = 8'h4c;
  localparam logic [7:0] OFS_PINS = 8'h50;

  // ****************************************************************
  // channel_output_control fields
  // ****************************************************************
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int IVL_BIT = 4;
  localparam int RLD_BIT = 5;
  localparam int INV_BIT = 6;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [NCH-1:0] FSEL_RST = 8'hff;
  localparam logic [NCH-1:0] FEN_RST = 8'h00;
  localparam logic [NCH-1:0] IMASK_RST = 8'h00;
  localparam logic [CNT_W-1:0] BASE_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    TCW_SINGLE = 3'h0,
    TCW_TOGGLE = 3'h1,
    TCW_SETRST = 3'h3,
    TCW_PHASE = 3'h2
  } tcw_mode_t;

endpackage

// ---- tcw_channel.sv ----
// one compare channel: compare buffer, match detect, output level
`timescale 1ns/10ps
module tcw_channel (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      enable,
  input  wire logic [2:0]                mode,
  input  wire logic                      initial_level_select,
  input  wire logic                      compare_load_timing,
  input  wire logic                      output_polarity_flip,
  input  wire logic                      cmp_wr,
  input  wire logic [tcw_pkg::CNT_W-1:0] cmp_wdata,
  input  wire logic                      bt_tick,
  input  wire logic [tcw_pkg::CNT_W-1:0] bt_count,
  output logic      [tcw_pkg::CNT_W-1:0] cmp_buf,
  output logic                           match_pulse,
  output logic                           pin
);
  import tcw_pkg::*;

  logic [CNT_W-1:0] buf_r, buf_nxt, act_r, act_nxt;
  logic             level_r, level_nxt, pin_r, pin_nxt;
  logic             match_r, match_nxt;
  logic             zero, match;

  // ****************************************************************
  // match and reload
  // ****************************************************************
  assign zero  = bt_tick && (bt_count == BASE_ZERO);
  assign match = enable && bt_tick && (bt_count == act_r);

  always_comb begin
    buf_nxt = cmp_wr ? cmp_wdata : buf_r;
    act_nxt = act_r;
    if (cmp_wr && !compare_load_timing) begin
      act_nxt = cmp_wdata;
    end else if (zero && compare_load_timing) begin
      act_nxt = buf_nxt;
    end
    match_nxt = match;
  end

  // ****************************************************************
  // waveform level
  // ****************************************************************
  always_comb begin
    level_nxt = level_r;
    if (!enable) begin
      level_nxt = initial_level_select;
    end else if (match) begin
      case (tcw_mode_t'(mode))
        TCW_SINGLE, TCW_SETRST: level_nxt = 1'b1;
        TCW_TOGGLE, TCW_PHASE:  level_nxt = ~level_r;
        default:                level_nxt = level_r;
      endcase
    end else if (zero) begin
      case (tcw_mode_t'(mode))
        TCW_SINGLE, TCW_SETRST: level_nxt = 1'b0;
        default:                level_nxt = level_r;
      endcase
    end
    pin_nxt = level_nxt ^ output_polarity_flip;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_r   <= CMP_RST;
      act_r   <= CMP_RST;
      level_r <= 1'b0;
      pin_r   <= 1'b0;
      match_r <= 1'b0;
    end else begin
      buf_r   <= buf_nxt;
      act_r   <= act_nxt;
      level_r <= level_nxt;
      pin_r   <= pin_nxt;
      match_r <= match_nxt;
    end
  end

  assign cmp_buf     = buf_r;
  assign match_pulse = match_r;
  assign pin         = pin_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_match_seen;
    @(posedge hclk) disable iff (!hresetn)
    (enable && bt_tick && bt_count == act_r) |=> match_r;
  endproperty
  a_match_seen: assert property (p_match_seen)
    else $error("compare match not flagged");

  property p_disabled_pin;
    @(posedge hclk) disable iff (!hresetn)
    !enable |=> (pin_r == ($past(initial_level_select) ^ $past(output_polarity_flip)));
  endproperty
  a_disabled_pin: assert property (p_disabled_pin)
    else $error("disabled pin not at initial level");

  property p_start_level;
    @(posedge hclk) disable iff (!hresetn)
    (!enable ##1 (enable && !match && !zero)) |=> (level_r == $past(initial_level_select, 2));
  endproperty
  a_start_level: assert property (p_start_level)
    else $error("start level differs from initial level");

  property p_polarity;
    @(posedge hclk) disable iff (!hresetn)
    ##1 (pin_r == (level_r ^ $past(output_polarity_flip)));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pin polarity wrong");

  property p_single_high;
    @(posedge hclk) disable iff (!hresetn)
    (match && mode == TCW_SINGLE) |=> level_r;
  endproperty
  a_single_high: assert property (p_single_high)
    else $error("single-phase not high after match");

  property p_single_low;
    @(posedge hclk) disable iff (!hresetn)
    (enable && zero && !match && mode == TCW_SINGLE) |=> !level_r;
  endproperty
  a_single_low: assert property (p_single_low)
    else $error("single-phase not low at zero");

  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
    (match && mode == TCW_TOGGLE) |=> (level_r != $past(level_r));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("inverted mode did not toggle");

  property p_reload_now;
    @(posedge hclk) disable iff (!hresetn)
    (cmp_wr && !compare_load_timing) |=> (act_r == $past(cmp_wdata));
  endproperty
  a_reload_now: assert property (p_reload_now)
    else $error("immediate reload missed");

  property p_reload_wait;
    @(posedge hclk) disable iff (!hresetn)
    (cmp_wr && compare_load_timing && !zero) |=> (act_r == $past(act_r));
  endproperty
  a_reload_wait: assert property (p_reload_wait)
    else $error("deferred reload taken early");

endmodule // tcw_channel

// ---- tcw_top.sv ----
// AHB-Lite register file and eight compare waveform channels
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module tcw_top (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      bt_tick,
  input  wire logic [tcw_pkg::CNT_W-1:0] bt_count,
  output logic      [tcw_pkg::NCH-1:0]   channel_output_pin,
  output logic                           irq
);
  import tcw_pkg::*;

  // ****************************************************************
  // bus phase tracking
  // ****************************************************************
  logic        wr_ph_r, wr_ph_nxt, rd_ph_r, rd_ph_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic        rdy_r, rdy_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        take;

  // all transfers are treated as whole words
  assign take = hsel && htrans[1] && hready;

  always_comb begin
    wr_ph_nxt = take && hwrite;
    rd_ph_nxt = take && !hwrite;
    addr_nxt  = take ? haddr[7:0] : addr_r;
    // reads wait one cycle so data is taken from a flop
    rdy_nxt   = !(take && !hwrite);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      addr_r  <= 8'h00;
      rdy_r   <= 1'b1;
    end else begin
      wr_ph_r <= wr_ph_nxt;
      rd_ph_r <= rd_ph_nxt;
      addr_r  <= addr_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [NCH-1:0][CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [NCH-1:0]             fsel_r, fsel_nxt, fen_r, fen_nxt;
  logic [NCH-1:0]             imask_r, imask_nxt, istat_r, istat_nxt;
  logic [NCH-1:0]             cmp_wr, match_p, chan_en;
  logic [NCH-1:0][CNT_W-1:0]  cmp_buf;
  logic [NCH-1:0]             pins;
  logic                       irq_r, irq_nxt;

  always_comb begin
    ctrl_nxt  = ctrl_r;
    fsel_nxt  = fsel_r;
    fen_nxt   = fen_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    cmp_wr    = '0;
    for (int i = 0; i < NCH; i++) begin
      if (wr_ph_r && addr_r == OFS_CTRL0 + 8'(4 * i)) begin
        ctrl_nxt[i] = hwdata[CTRL_W-1:0];
      end
      if (wr_ph_r && addr_r == OFS_CMP0 + 8'(4 * i)) begin
        cmp_wr[i] = 1'b1;
      end
    end
    if (wr_ph_r && addr_r == OFS_FSEL) begin
      fsel_nxt = hwdata[NCH-1:0];
    end
    if (wr_ph_r && addr_r == OFS_FEN) begin
      fen_nxt = hwdata[NCH-1:0];
    end
    if (wr_ph_r && addr_r == OFS_IMASK) begin
      imask_nxt = hwdata[NCH-1:0];
    end
    if (wr_ph_r && addr_r == OFS_ISTAT) begin
      istat_nxt = istat_r & ~hwdata[NCH-1:0];
    end
    // a match in the clearing cycle still sets its flag
    istat_nxt = istat_nxt | match_p;
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r  <= {NCH{CTRL_RST}};
      fsel_r  <= FSEL_RST;
      fen_r   <= FEN_RST;
      imask_r <= IMASK_RST;
      istat_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      fsel_r  <= fsel_nxt;
      fen_r   <= fen_nxt;
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      if (addr_r == OFS_CTRL0 + 8'(4 * i)) begin
        rdata_nxt[CTRL_W-1:0] = ctrl_r[i];
      end
      if (addr_r == OFS_CMP0 + 8'(4 * i)) begin
        rdata_nxt[CNT_W-1:0] = cmp_buf[i];
      end
    end
    case (addr_r)
      OFS_FSEL:  rdata_nxt[NCH-1:0] = fsel_r;
      OFS_FEN:   rdata_nxt[NCH-1:0] = fen_r;
      OFS_ISTAT: rdata_nxt[NCH-1:0] = istat_r;
      OFS_IMASK: rdata_nxt[NCH-1:0] = imask_r;
      OFS_PINS:  rdata_nxt[NCH-1:0] = pins;
      default:   rdata_nxt = rdata_nxt;
    endcase
    if (!rd_ph_r) begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  // waveform output only when selected for generation and enabled
  assign chan_en = fen_r & ~fsel_r;

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      tcw_channel u_ch (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .enable      (chan_en[g]),
        .mode        (ctrl_r[g][MODE_MSB:MODE_LSB]),
        .initial_level_select         (ctrl_r[g][IVL_BIT]),
        .compare_load_timing         (ctrl_r[g][RLD_BIT]),
        .output_polarity_flip         (ctrl_r[g][INV_BIT]),
        .cmp_wr      (cmp_wr[g]),
        .cmp_wdata   (hwdata[CNT_W-1:0]),
        .bt_tick     (bt_tick),
        .bt_count    (bt_count),
        .cmp_buf     (cmp_buf[g]),
        .match_pulse (match_p[g]),
        .pin         (pins[g])
      );
    end
  endgenerate

  assign hrdata             = rdata_r;
  assign hreadyout          = rdy_r;
  assign hresp              = 1'b0;
  assign channel_output_pin = pins;
  assign irq                = irq_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    (match_p != '0) |=> ((istat_r & $past(match_p)) == $past(match_p));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match did not set interrupt flag");

  property p_enable_gate;
    @(posedge hclk) disable iff (!hresetn)
    (fsel_r != '0) |-> ((chan_en & fsel_r) == '0);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("measurement channel drives waveform");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
    ##1 (irq_r == |(istat_r & imask_r));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output out of step");

endmodule // tcw_top

// ---- tcw_pin_load.sv ----
// external load on the channel pins: counts level changes per pin
`timescale 1ns/10ps
module tcw_pin_load (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic [tcw_pkg::NCH-1:0]      pin,
  output logic      [tcw_pkg::NCH-1:0][7:0] toggles
);
  import tcw_pkg::*;
  logic [NCH-1:0]      last_r;
  logic [NCH-1:0][7:0] cnt_r;
  logic [NCH-1:0][7:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    for (int j = 0; j < NCH; j++) begin
      if (pin[j] != last_r[j]) begin
        cnt_nxt[j] = cnt_r[j] + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_r <= '0;
      cnt_r  <= '0;
    end else begin
      last_r <= pin;
      cnt_r  <= cnt_nxt;
    end
  end

  assign toggles = cnt_r;
endmodule // tcw_pin_load

// ---- timer_compare_waveform_gen_tb.sv ----
// self-checking bench for the compare waveform generator
`timescale 1ns/10ps
module timer_compare_waveform_gen_tb;
  import tcw_pkg::*;
  logic                hclk = 1'b0;
  logic                hresetn = 1'b0;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [2:0]          hsize = 3'h2;
  logic [31:0]         hwdata = 32'h0;
  logic                hready;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic                bt_tick = 1'b0;
  logic [CNT_W-1:0]    bt_count = 16'h0;
  logic [NCH-1:0]      pins;
  logic                irq;
  logic [NCH-1:0][7:0] toggles;
  int                  err_count = 0;
  int                  cmp_count = 0;

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  tcw_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bt_tick(bt_tick), .bt_count(bt_count), .channel_output_pin(pins),
    .irq(irq));
  tcw_pin_load load (.hclk(hclk), .hresetn(hresetn), .pin(pins),
    .toggles(toggles));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      err_count++;
    end
  endtask

  task automatic pchk(input int j, input logic e, input string m);
    chk({31'h0, pins[j]}, {31'h0, e}, m);
  endtask

  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e, m);
  endtask

  // one base timer step, then time for pin, status and counter to settle
  task automatic tick(input logic [CNT_W-1:0] c);
    bt_tick  <= 1'b1;
    bt_count <= c;
    @(posedge hclk);
    bt_tick  <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    $display("MISMATCH %0t watchdog expired", $time);
    err_count++;
    tally_and_finish();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    tcw_mode_t   md [4];
    logic [7:0]  base;
    logic        tg;
    md = '{TCW_SINGLE, TCW_TOGGLE, TCW_SETRST, TCW_PHASE};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(OFS_CTRL0, 32'h0, "ctrl reset");
    rdc(OFS_CMP0, 32'h0, "compare reset");
    rdc(OFS_FSEL, 32'hff, "select reset");
    rdc(OFS_FEN, 32'h0, "enable reset");
    rdc(8'h80, 32'h0, "unmapped read");
    pchk(0, 1'b0, "pin reset");
    $display("test reset values done");
    for (int j = 0; j < 4; j++) begin
      wr(OFS_CTRL0 + 8'(4 * j),
         (32'(j % 2) << IVL_BIT) | (32'(j / 2) << INV_BIT));
    end
    repeat (3) @(posedge hclk);
    for (int j = 0; j < 4; j++) begin
      pchk(j, 1'(j % 2 ^ j / 2), "idle level");
    end
    rdc(OFS_PINS, 32'h6, "pin levels");
    $display("test idle levels done");
    // base timer is driven by the bench after the channels are set up
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CMP0, 32'h5);
    wr(OFS_FSEL, 32'hfe);
    wr(OFS_FEN, 32'h11);
    wr(OFS_CMP0 + 8'h10, 32'h5);
    tick(16'h5);
    pchk(0, 1'b1, "single set");
    pchk(4, 1'b0, "select blocks");
    tick(16'h3);
    pchk(0, 1'b1, "single holds");
    tick(16'h0);
    pchk(0, 1'b0, "single clear");
    rdc(OFS_ISTAT, 32'h1, "status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(OFS_IMASK, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1, "irq on");
    rdc(OFS_IMASK, 32'h1, "mask readback");
    wr(OFS_ISTAT, 32'h1);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq off");
    rdc(OFS_ISTAT, 32'h0, "status cleared");
    $display("test single and interrupt done");
    wr(OFS_CMP0 + 8'h04, 32'h7);
    wr(OFS_FSEL, 32'hfc);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FEN, 32'h0);
      wr(OFS_CTRL0 + 8'h04, {29'h0, md[i]});
      repeat (3) @(posedge hclk);
      pchk(1, 1'b0, "stop level");
      base = toggles[1];
      tg = (md[i] == TCW_TOGGLE) || (md[i] == TCW_PHASE);
      wr(OFS_FEN, 32'h2);
      tick(16'h7);
      pchk(1, 1'b1, "first match");
      tick(16'h7);
      pchk(1, !tg, "second match");
      chk({24'h0, toggles[1] - base}, tg ? 32'h2 : 32'h1, "edges");
    end
    $display("test modes done");
    wr(OFS_FEN, 32'h0);
    wr(OFS_CTRL0, 32'h1 << RLD_BIT);
    wr(OFS_CMP0, 32'h9);
    rdc(OFS_CMP0, 32'h9, "compare buffer");
    wr(OFS_FEN, 32'h1);
    tick(16'h9);
    pchk(0, 1'b0, "reload waits");
    tick(16'h0);
    tick(16'h9);
    pchk(0, 1'b1, "reload at zero");
    $display("test reload done");
    tally_and_finish();
  end
endmodule // timer_compare_waveform_gen_tb
